// ===== pkg/pef_event_map.svh
// pef_event_map.svh: command codes, bit positions, reset values and timing
// for the per-channel event flag block.
// assumes: included by its bare name from the package and the design files.
`ifndef PEF_EVENT_MAP_SVH
`define PEF_EVENT_MAP_SVH

// ==========================================================
// geometry
`define PEF_NCH 4
`define PEF_HI_LSB 4

// ==========================================================
// command codes, plain read and clear-on-read pairs
`define PEF_CMD_DISC_PEEK 8'h04
`define PEF_CMD_DISC_TAKE 8'h05
`define PEF_CMD_FAULT_PEEK 8'h06
`define PEF_CMD_FAULT_TAKE 8'h07
`define PEF_CMD_SL_PEEK 8'h08
`define PEF_CMD_SL_TAKE 8'h09
`define PEF_CMD_SUP_PEEK 8'h0A
`define PEF_CMD_SUP_TAKE 8'h0B

// ==========================================================
// reset values and reserved bits
`define PEF_FLAGS_RST 8'h00
`define PEF_SUP_RST 8'h70
`define PEF_SUP_RSVD 8'h0C

// ==========================================================
// interrupt summary bit positions
`define PEF_SUM_SUPPLY 7
`define PEF_SUM_START 6
`define PEF_SUM_LIMIT 5
`define PEF_SUM_CLASS 4
`define PEF_SUM_DETECT 3
`define PEF_SUM_DISC 2
`define PEF_SUM_PWR_LSB 0

// ==========================================================
// timing
`define PEF_MCLK_MHZ 40
`define PEF_LIMIT_TIMER_COUNTER_US 60
`define PEF_OVERLOAD_TIMER_COUNTER_US 60
`define PEF_LIMIT_TIMER_COUNTER_CYC (`PEF_LIMIT_TIMER_COUNTER_US * `PEF_MCLK_MHZ)
`define PEF_OVERLOAD_TIMER_COUNTER_CYC (`PEF_OVERLOAD_TIMER_COUNTER_US * `PEF_MCLK_MHZ)

`endif

// ===== pkg/pef_pkg.sv
// pef_pkg.sv: types shared by the event flag block.
// assumes: pef_event_map.svh is on the include path.
`default_nettype none
package pef_pkg;
    `include "pef_event_map.svh"
    typedef logic [7:0] pef_byte_t;
    typedef logic [3:0] pef_class_t;
    typedef logic [2:0] pef_det_t;
endpackage
`default_nettype wire

// ===== pkg/pef_tmr_if.sv
// pef_tmr_if.sv: levels to the per-channel fault timers and their pulses back.
// assumes: both ends run on mclk.
`timescale 1ns/1ps
`default_nettype none
interface pef_tmr_if #(parameter int NCH = 4);
    logic [NCH-1:0] at_limit;
    logic [NCH-1:0] overload;
    logic [NCH-1:0] lim_fault;
    logic [NCH-1:0] ovl_fault;
    modport timer (input at_limit, input overload, output lim_fault, output ovl_fault);
    modport core (output at_limit, output overload, input lim_fault, input ovl_fault);
endinterface
`default_nettype wire

// ===== logic/pef_fault_timer.sv
// pef_fault_timer.sv: per-channel limit and overload timing counters.
// assumes: levels are synchronous to mclk; a fault pulse is one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pef_event_map.svh"
module pef_fault_timer
    import pef_pkg::*;
#(
    parameter int NCH = 4,
    parameter int unsigned LIM_CYC = `PEF_LIMIT_TIMER_COUNTER_CYC,
    parameter int unsigned OVL_CYC = `PEF_OVERLOAD_TIMER_COUNTER_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // levels in, pulses out
    pef_tmr_if.timer tif
);
    localparam int unsigned MAXC = (LIM_CYC > OVL_CYC) ? LIM_CYC : OVL_CYC;
    localparam int CW = $clog2(MAXC + 1);

    logic [2*NCH-1:0] lvl;
    logic [2*NCH-1:0] fire_q;

    assign lvl = {tif.overload, tif.at_limit};
    assign tif.lim_fault = fire_q[NCH-1:0];
    assign tif.ovl_fault = fire_q[2*NCH-1:NCH];

    // low half times the limit, high half the overload
    for (genvar k = 0; k < 2 * NCH; k++) begin : g_cnt
        localparam logic [CW-1:0] LAST = CW'(((k < NCH) ? LIM_CYC : OVL_CYC) - 1);
        logic [CW-1:0] cnt_q;
        // no flag clear reaches these counters, only the level does
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                cnt_q <= '0;
                fire_q[k] <= 1'b0;
            end else if (lvl[k]) begin
                if (cnt_q != LAST + CW'(1)) begin
                    cnt_q <= cnt_q + CW'(1);
                end
                fire_q[k] <= (cnt_q == LAST);
            end else begin
                cnt_q <= '0;
                fire_q[k] <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== logic/pef_event_flags.sv
// pef_event_flags.sv: detection, fault, start/limit and supply event flags
// with plain and clear-on-read command codes, summary bits and interrupt.
// assumes: the command engine and all event sources run on mclk; event
// inputs are one-cycle pulses, at_limit and overload are levels.
`timescale 1ns/1ps
`default_nettype none
`include "pef_event_map.svh"

// Functional notes
// - bits 7-4 detection: class flags; any cycle, or class change when selected
// - bits 3-0 detection: detect flags; any cycle, or result change when selected
// - flags active high; each group's four bits are channels one to four
// - fault register: 06h plain read, 07h read then clear all
// - channel switched off clears its bits in detection, fault, start/limit
// - clear-on-read releases the interrupt unless another unmasked source holds it
// - any set flag shows in its summary bit
// - fault register: disconnect bits 7-4, overload bits 3-0, reset zero
// - clearing overload flags leaves limit and overload counters alone
// - start/limit register: 08h plain read, 09h read then clear
// - bits 7-4 start/limit set when current held at limit past timeout
// - bits 3-0 start/limit set on start timeout or discovery error
// - start fault with power enable change is inrush, else cause logged
// - auto mode: discovery errors set no start flag, log nothing
// - supply register: 0Ah plain read, 0Bh read then clear
// - supply bits: thermal, logic uv, logic warn, rail uv, rsvd, shutdown, memory
// - mask bit zero blocks that class from interrupt; summary still tracks
// - interrupt needs the global enable as well as the mask bit
module pef_event_flags
    import pef_pkg::*;
#(
    parameter int unsigned LIM_CYC = `PEF_LIMIT_TIMER_COUNTER_CYC,
    parameter int unsigned OVL_CYC = `PEF_OVERLOAD_TIMER_COUNTER_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // command read port from the serial engine
    input wire logic rd_stb,
    input wire logic [7:0] rd_cmd,
    output logic rd_valid,
    output logic [7:0] rd_data,
    // configuration
    input wire logic class_change_select,
    input wire logic detect_change_select,
    input wire logic auto_mode,
    input wire logic [7:0] event_mask,
    input wire logic global_interrupt_enable,
    input wire logic [1:0] power_event_pending,
    // discovery results
    input wire logic [3:0] class_done,
    input wire logic [15:0] class_result,
    input wire logic [3:0] detect_done,
    input wire logic [11:0] detect_result,
    // channel faults and state
    input wire logic [3:0] disconnect_evt,
    input wire logic [3:0] at_limit,
    input wire logic [3:0] overload,
    input wire logic [3:0] start_timeout,
    input wire logic [3:0] discovery_err,
    input wire logic [3:0] power_enable_change_flag,
    input wire logic [3:0] channel_off,
    // supply events, bit per field
    input wire logic [7:0] supply_evt,
    // flags and interrupt
    output logic [7:0] discovery_flags,
    output logic [7:0] fault_flags,
    output logic [7:0] start_limit_flags,
    output logic [7:0] supply_flags,
    output logic [7:0] int_summary,
    output logic int_n,
    // power-on fault logging
    output logic [3:0] pof_load,
    output logic [3:0] inrush_fault
);
    localparam int NCH = `PEF_NCH;
    localparam int HI = `PEF_HI_LSB;

    // ==========================================================
    // helpers

    // set wins over clear so a colliding event survives
    function automatic pef_byte_t upd(pef_byte_t q, pef_byte_t set, pef_byte_t clr);
        return (q & ~clr) | set;
    endfunction

    // one command hit, used by every register pair
    function automatic logic hit(logic stb, logic [7:0] cmd, logic [7:0] code);
        return stb && (cmd == code);
    endfunction

    // ==========================================================
    // fault timers
    pef_tmr_if #(.NCH(NCH)) tif ();

    assign tif.at_limit = at_limit;
    assign tif.overload = overload;

    pef_fault_timer #(
        .NCH(NCH),
        .LIM_CYC(LIM_CYC),
        .OVL_CYC(OVL_CYC)
    ) u_timer (
        .mclk(mclk),
        .rstn(rstn),
        .tif(tif)
    );

    // ==========================================================
    // discovery: cycle or change detect
    pef_class_t cls_prev_q [NCH];
    pef_det_t det_prev_q [NCH];
    logic [NCH-1:0] cls_set;
    logic [NCH-1:0] det_set;

    for (genvar i = 0; i < NCH; i++) begin : g_disc
        pef_class_t cls_now;
        pef_det_t det_now;
        assign cls_now = class_result[4*i +: 4];
        assign det_now = detect_result[3*i +: 3];
        assign cls_set[i] = class_done[i]
            && (!class_change_select || cls_now != cls_prev_q[i]);
        assign det_set[i] = detect_done[i]
            && (!detect_change_select || det_now != det_prev_q[i]);
        // last result per channel, kept for the change compare
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                cls_prev_q[i] <= '0;
                det_prev_q[i] <= '0;
            end else begin
                if (class_done[i]) begin
                    cls_prev_q[i] <= cls_now;
                end
                if (detect_done[i]) begin
                    det_prev_q[i] <= det_now;
                end
            end
        end
    end

    // ==========================================================
    // set and clear terms
    pef_byte_t off_clr;
    pef_byte_t disc_set, fault_set, sl_set, sup_set;
    logic [NCH-1:0] strt_set;
    logic take_disc, take_fault, take_sl, take_sup;

    // channel n owns bit n and bit n+4 of each group register
    assign off_clr = {channel_off, channel_off};
    // discovery errors are invalid results in auto mode and are dropped
    assign strt_set = start_timeout | (discovery_err & ~{NCH{auto_mode}});
    assign disc_set = {cls_set, det_set};
    assign fault_set = {disconnect_evt, tif.ovl_fault};
    assign sl_set = {tif.lim_fault, strt_set};
    assign sup_set = supply_evt & ~`PEF_SUP_RSVD;

    assign take_disc = hit(rd_stb, rd_cmd, `PEF_CMD_DISC_TAKE);
    assign take_fault = hit(rd_stb, rd_cmd, `PEF_CMD_FAULT_TAKE);
    assign take_sl = hit(rd_stb, rd_cmd, `PEF_CMD_SL_TAKE);
    assign take_sup = hit(rd_stb, rd_cmd, `PEF_CMD_SUP_TAKE);

    // ==========================================================
    // flag registers
    pef_byte_t disc_q, fault_q, sl_q, sup_q;
    pef_byte_t disc_d, fault_d, sl_d, sup_d;

    assign disc_d = upd(disc_q, disc_set, {8{take_disc}} | off_clr);
    // the timers see no clear, only these flags do
    assign fault_d = upd(fault_q, fault_set, {8{take_fault}} | off_clr);
    assign sl_d = upd(sl_q, sl_set, {8{take_sl}} | off_clr);
    // supply flags are not per channel and ignore channel off
    assign sup_d = upd(sup_q, sup_set, {8{take_sup}});

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            disc_q <= `PEF_FLAGS_RST;
            fault_q <= `PEF_FLAGS_RST;
            sl_q <= `PEF_FLAGS_RST;
            sup_q <= `PEF_SUP_RST;
        end else begin
            disc_q <= disc_d;
            fault_q <= fault_d;
            sl_q <= sl_d;
            sup_q <= sup_d;
        end
    end

    assign discovery_flags = disc_q;
    assign fault_flags = fault_q;
    assign start_limit_flags = sl_q;
    assign supply_flags = sup_q;

    // ==========================================================
    // command read: data captured before the clear lands
    pef_byte_t rd_data_q;
    logic rd_valid_q;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= '0;
        end else begin
            rd_valid_q <= rd_stb;
            if (rd_stb) begin
                case (rd_cmd)
                    `PEF_CMD_DISC_PEEK, `PEF_CMD_DISC_TAKE: begin
                        rd_data_q <= disc_q;
                    end
                    `PEF_CMD_FAULT_PEEK, `PEF_CMD_FAULT_TAKE: begin
                        rd_data_q <= fault_q;
                    end
                    `PEF_CMD_SL_PEEK, `PEF_CMD_SL_TAKE: begin
                        rd_data_q <= sl_q;
                    end
                    `PEF_CMD_SUP_PEEK, `PEF_CMD_SUP_TAKE: begin
                        rd_data_q <= sup_q;
                    end
                    default: begin
                        rd_data_q <= '0;
                    end
                endcase
            end
        end
    end

    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;

    // ==========================================================
    // summary and interrupt, built from next values so both move with flags
    pef_byte_t sum_d;
    pef_byte_t sum_q;
    logic int_n_q;

    always_comb begin
        sum_d = '0;
        sum_d[`PEF_SUM_SUPPLY] = |sup_d;
        sum_d[`PEF_SUM_START] = |sl_d[HI-1:0];
        sum_d[`PEF_SUM_LIMIT] = |sl_d[7:HI] || |fault_d[HI-1:0];
        sum_d[`PEF_SUM_CLASS] = |disc_d[7:HI];
        sum_d[`PEF_SUM_DETECT] = |disc_d[HI-1:0];
        sum_d[`PEF_SUM_DISC] = |fault_d[7:HI];
        sum_d[`PEF_SUM_PWR_LSB +: 2] = power_event_pending;
    end

    // summary ignores the mask; the pin does not
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sum_q <= '0;
            int_n_q <= 1'b1;
        end else begin
            sum_q <= sum_d;
            int_n_q <= !(global_interrupt_enable && |(sum_d & event_mask));
        end
    end

    assign int_summary = sum_q;
    assign int_n = int_n_q;

    // ==========================================================
    // power-on fault logging and inrush marking
    logic [NCH-1:0] pof_q, inrush_q;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pof_q <= '0;
            inrush_q <= '0;
        end else begin
            pof_q <= strt_set & ~power_enable_change_flag;
            inrush_q <= strt_set & power_enable_change_flag;
        end
    end

    assign pof_load = pof_q;
    assign inrush_fault = inrush_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_fault_take_clear: assert property (
        take_fault && fault_set == '0 |=> fault_q == '0)
        else $error("fault take did not clear");
    a_fault_peek_hold: assert property (
        hit(rd_stb, rd_cmd, `PEF_CMD_FAULT_PEEK) && fault_set == '0
        && channel_off == '0 |=> fault_q == $past(fault_q))
        else $error("fault peek changed flags");
    a_read_returns_old: assert property (
        take_sl |=> rd_valid && rd_data == $past(sl_q))
        else $error("start limit read data wrong");
    a_set_wins_take: assert property (
        take_fault |=> (fault_q & $past(fault_set)) == $past(fault_set))
        else $error("event lost under take");
    a_off_clears_chan: assert property (
        channel_off != '0 |=> (sl_q & $past(off_clr & ~sl_set)) == '0)
        else $error("channel off left flags");
    a_auto_no_start: assert property (
        auto_mode && (discovery_err & ~start_timeout) != '0
        |=> ((sl_q[HI-1:0] & ~$past(sl_q[HI-1:0]))
        & $past(discovery_err & ~start_timeout)) == '0
        && (pof_load & $past(discovery_err & ~start_timeout)) == '0)
        else $error("auto mode set start flag");
    a_class_change_only: assert property (
        class_change_select && class_done[0] && !disc_q[HI]
        && class_result[3:0] == cls_prev_q[0] |=> !disc_q[HI])
        else $error("class flag without change");
    a_int_gate_mask: assert property (
        ##1 int_n == !($past(global_interrupt_enable)
        && |(int_summary & $past(event_mask))))
        else $error("interrupt gating wrong");
    a_summary_track: assert property (
        int_summary[`PEF_SUM_DISC] == |fault_q[7:HI])
        else $error("summary lost disconnect");
    a_supply_rsvd_zero: assert property (
        (sup_q & `PEF_SUP_RSVD) == '0)
        else $error("reserved supply bit set");

    a_rd_answer_next: assert property (
        rd_stb |=> rd_valid)
        else $error("read not answered");

    a_sup_take_clear: assert property (
        take_sup && sup_set == '0 |=> supply_flags == '0)
        else $error("supply take did not clear");

    a_start_split: assert property (
        strt_set != '0 |=> (pof_load | inrush_fault) == $past(strt_set)
        && (pof_load & inrush_fault) == '0)
        else $error("start fault cause split wrong");

    c_take_release: cover property (take_fault ##1 $rose(int_n));
    c_limit_fault: cover property ($rose(sl_q[HI]));
    c_inrush: cover property (inrush_fault[0]);
    c_detect_change: cover property (detect_change_select && det_set[0]);
endmodule
`default_nettype wire

// ===== dv/pef_host_model.sv
// pef_host_model.sv: host side of the command read port of the event flags.
// assumes: single clock mclk; the caller's checker watches rd_valid and rd_data.
`timescale 1ns/1ps
`default_nettype none
module pef_host_model (
    // clock
    input wire logic mclk,
    // command read port
    output logic rd_stb,
    output logic [7:0] rd_cmd,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data
);
    // idle at time zero so nothing is taken during reset
    initial begin
        rd_stb = 1'b0;
        rd_cmd = 8'h00;
    end
    // ==========================================================
    // one command byte, one answer byte; the code line is scrambled after
    // release so a stale code can never look like a held request
    task automatic read(input logic [7:0] cmd);
        @(posedge mclk);
        rd_stb <= 1'b1;
        rd_cmd <= cmd;
        @(posedge mclk);
        rd_stb <= 1'b0;
        rd_cmd <= ~cmd;
    endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// testbench.sv: self-checking bench for the event flag block.
// assumes: pef_pkg and the host model are compiled first; timers shortened to 8.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pef_pkg::*;
    localparam int CYC = 8;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic rd_stb, rd_valid, ccs, dcs, auto_mode, gie, int_n;
    logic [7:0] rd_cmd, rd_data, event_mask, supply_evt, dflg, fflg, sflg, pflg, isum;
    logic [1:0] pend;
    logic [3:0] class_done, detect_done, disc, at_limit, overload, st_to, d_err, pec, ch_off;
    logic [3:0] pof, inr, r;
    logic [15:0] class_result;
    logic [11:0] detect_result;
    logic [7:0] exp_q[$];
    logic [7:0] cmds[8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B};
    logic [7:0] vals[8] = '{8'h00, 8'h00, 8'h20, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
    int errors = 0;
    int n_checks = 0;

    always #12.5 mclk = ~mclk;

    pef_event_flags #(.LIM_CYC(CYC), .OVL_CYC(CYC)) i_dut (
        .mclk(mclk), .rstn(rstn), .rd_stb(rd_stb), .rd_cmd(rd_cmd), .rd_valid(rd_valid),
        .rd_data(rd_data), .class_change_select(ccs), .detect_change_select(dcs),
        .auto_mode(auto_mode), .event_mask(event_mask), .global_interrupt_enable(gie),
        .power_event_pending(pend), .class_done(class_done), .class_result(class_result),
        .detect_done(detect_done), .detect_result(detect_result), .disconnect_evt(disc),
        .at_limit(at_limit), .overload(overload), .start_timeout(st_to),
        .discovery_err(d_err), .power_enable_change_flag(pec), .channel_off(ch_off),
        .supply_evt(supply_evt), .discovery_flags(dflg), .fault_flags(fflg),
        .start_limit_flags(sflg), .supply_flags(pflg), .int_summary(isum), .int_n(int_n),
        .pof_load(pof), .inrush_fault(inr));

    pef_host_model i_host (.mclk(mclk), .rd_stb(rd_stb), .rd_cmd(rd_cmd),
        .rd_valid(rd_valid), .rd_data(rd_data));

    // ==========================================================
    // helpers
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // note the answer first, then let the host issue the command
    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.read(c);
    endtask
    task automatic nx;
        @(posedge mclk);
        @(negedge mclk);
    endtask
    // pulses last exactly one sampled edge
    task automatic settle;
        @(posedge mclk);
        {class_done, detect_done, disc, st_to, d_err, ch_off} <= '0;
        supply_evt <= 8'h00;
        @(negedge mclk);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================================
    // answer watcher: oldest note against each answer byte
    always @(posedge mclk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("spare answer", 8'h00, 8'hFF);
            end else begin
                chk("rd_data", exp_q.pop_front(), rd_data);
            end
        end
    end

    // watchdog, well past the expected hundred or so cycles
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        $display("BAD watchdog expected done seen hang");
        results();
    end

    // ==========================================================
    // main sequence
    initial begin
        {ccs, dcs, auto_mode, gie, pend, event_mask, supply_evt} = '0;
        {class_done, detect_done, disc, at_limit, overload, st_to, d_err, pec, ch_off} = '0;
        class_result = '0;
        detect_result = '0;
        r = 4'($urandom(90));
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        chk("fault_flags", 8'h00, fflg);
        chk("supply_flags", 8'h70, pflg);
        chk("int_n", 8'h01, {7'h0, int_n});
        @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) nx();
        chk("int_summary", 8'h80, isum);
        // interrupt gating by mask and global enable
        @(posedge mclk);
        event_mask <= 8'h80;
        gie <= 1'b1;
        nx();
        chk("int_n", 8'h00, {7'h0, int_n});
        @(posedge mclk);
        gie <= 1'b0;
        nx();
        chk("int_n", 8'h01, {7'h0, int_n});
        @(posedge mclk);
        gie <= 1'b1;
        event_mask <= 8'h00;
        nx();
        chk("int_n", 8'h01, {7'h0, int_n});
        chk("int_summary", 8'h80, isum);
        @(posedge mclk);
        event_mask <= 8'h81;
        pend <= 2'b01;
        nx();
        rd(8'h0B, 8'h70);
        @(negedge mclk);
        chk("int_n", 8'h00, {7'h0, int_n});
        chk("int_summary", 8'h01, isum);
        @(posedge mclk);
        pend <= 2'b00;
        nx();
        chk("int_n", 8'h01, {7'h0, int_n});
        // supply fields, reserved bits stay clear
        @(posedge mclk);
        supply_evt <= 8'hFF;
        settle();
        chk("supply_flags", 8'hF3, pflg);
        rd(8'h0A, 8'hF3);
        rd(8'h0B, 8'hF3);
        rd(8'h0A, 8'h00);
        // fault flags; a clear partway through the overload time
        if (r == 4'h0) r = 4'h9;
        @(posedge mclk);
        disc <= r;
        overload <= 4'h1;
        settle();
        chk("fault_flags", {r, 4'h0}, fflg);
        rd(8'h06, {r, 4'h0});
        rd(8'h07, {r, 4'h0});
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk("fault_flags", 8'h01, fflg);
        @(posedge mclk);
        overload <= 4'h0;
        rd(8'h06, 8'h01);
        // event landing on the clearing edge survives
        fork
            rd(8'h07, 8'h01);
            begin
                @(posedge mclk);
                disc <= 4'h2;
                @(posedge mclk);
                disc <= 4'h0;
            end
        join
        settle();
        chk("fault_flags", 8'h20, fflg);
        // start faults, inrush split, limit timeout
        @(posedge mclk);
        at_limit <= 4'h2;
        pec <= 4'h1;
        st_to <= 4'h3;
        settle();
        chk("pof_load", 8'h02, {4'h0, pof});
        chk("inrush_fault", 8'h01, {4'h0, inr});
        chk("start_limit_flags", 8'h03, sflg);
        repeat (CYC + 2) @(posedge mclk);
        at_limit <= 4'h0;
        @(negedge mclk);
        chk("start_limit_flags", 8'h23, sflg);
        @(posedge mclk);
        auto_mode <= 1'b1;
        d_err <= 4'h4;
        settle();
        chk("start_limit_flags", 8'h23, sflg);
        chk("pof_load", 8'h00, {4'h0, pof});
        @(posedge mclk);
        auto_mode <= 1'b0;
        d_err <= 4'h8;
        settle();
        chk("start_limit_flags", 8'h2B, sflg);
        chk("int_summary", 8'h64, isum);
        rd(8'h08, 8'h2B);
        rd(8'h09, 8'h2B);
        rd(8'h08, 8'h00);
        // discovery flags: any cycle versus change only
        @(posedge mclk);
        dcs <= 1'b1;
        detect_done <= 4'hF;
        class_done <= 4'h1;
        settle();
        chk("discovery_flags", 8'h10, dflg);
        chk("int_summary", 8'h10, isum & 8'h18);
        @(posedge mclk);
        detect_done <= 4'h2;
        detect_result <= 12'h008;
        settle();
        chk("discovery_flags", 8'h12, dflg);
        rd(8'h05, 8'h12);
        @(posedge mclk);
        ccs <= 1'b1;
        class_done <= 4'h1;
        settle();
        chk("discovery_flags", 8'h00, dflg);
        @(posedge mclk);
        class_done <= 4'h4;
        class_result <= 16'h0300;
        disc <= 4'h4;
        st_to <= 4'h4;
        settle();
        chk("discovery_flags", 8'h40, dflg);
        // switching a channel off drops only its bits
        @(posedge mclk);
        ch_off <= 4'h4;
        settle();
        chk("discovery_flags", 8'h00, dflg);
        chk("fault_flags", 8'h20, fflg);
        chk("start_limit_flags", 8'h00, sflg);
        chk("int_summary", 8'h04, isum);
        rd(8'h3C, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rd(cmds[i], vals[i]);
        end
        repeat (3) @(posedge mclk);
        chk("pending answers", 8'h00, 8'(exp_q.size()));
        results();
    end
endmodule
`default_nettype wire
